// File: hamd_pkg.sv
// Constants and types for the host address map decoder
package hamd_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] HAMD_OFS_SEG_ATTR = 5'h00;
  localparam logic [4:0] HAMD_OFS_LEGACY_CTRL = 5'h04;
  localparam logic [4:0] HAMD_OFS_TOP_MAIN = 5'h08;
  localparam logic [4:0] HAMD_OFS_MGMT_SIZE = 5'h0C;
  localparam logic [4:0] HAMD_OFS_STATUS = 5'h10;
  localparam logic [4:0] HAMD_OFS_TOP_SYS = 5'h14;

  // Reset values
  localparam logic [25:0] HAMD_SEG_ATTR_RST = 26'h0000000;
  localparam logic [9:0] HAMD_LEGACY_CTRL_RST = 10'h000;
  localparam logic [11:0] HAMD_TOP_MAIN_RST = 12'h000;
  localparam logic [1:0] HAMD_MGMT_SIZE_RST = 2'h0;

  // Legacy control field positions
  localparam int HAMD_LC_VGA_EN = 0;
  localparam int HAMD_LC_MONO_PRESENT = 1;
  localparam int HAMD_LC_IGU_EN = 2;
  localparam int HAMD_LC_COMPAT_EN = 3;
  localparam int HAMD_LC_HIGH_EN = 4;
  localparam int HAMD_LC_TOP_EN = 5;
  localparam int HAMD_LC_HOLE_EN = 6;
  localparam int HAMD_LC_GFX_LO = 8;
  localparam int HAMD_LC_GFX_HI = 9;

  // Segment attribute layout: {write_enable, read_enable} per segment
  localparam int HAMD_NUM_SEGS = 13;
  localparam int HAMD_BIOS_SEG = 12;
  localparam logic [3:0] HAMD_BIOS_NIBBLE = 4'hF;

  // Address map
  localparam logic [31:0] HAMD_LOW_DRAM_END = 32'h0009_FFFF;
  localparam logic [31:0] HAMD_VGA_BASE = 32'h000A_0000;
  localparam logic [31:0] HAMD_VGA_END = 32'h000B_FFFF;
  localparam logic [31:0] HAMD_MONO_BASE = 32'h000B_0000;
  localparam logic [31:0] HAMD_MONO_END = 32'h000B_7FFF;
  localparam logic [31:0] HAMD_SEG_BASE = 32'h000C_0000;
  localparam logic [31:0] HAMD_SEG_END = 32'h000F_FFFF;
  localparam logic [31:0] HAMD_HOLE_BASE = 32'h00F0_0000;
  localparam logic [31:0] HAMD_HOLE_END = 32'h00FF_FFFF;
  localparam logic [31:0] HAMD_HIGH_SIZE = 32'h0002_0000;
  localparam logic [31:0] HAMD_TOP_MIN_SIZE = 32'h0002_0000;
  localparam logic [31:0] HAMD_GFX_512K = 32'h0008_0000;
  localparam logic [31:0] HAMD_GFX_1M = 32'h0010_0000;
  localparam logic [31:0] HAMD_GFX_8M = 32'h0080_0000;
  localparam logic [19:0] HAMD_MB_LOW_ZERO = 20'h00000;

  // Monochrome adapter I/O ports
  localparam logic [15:0] HAMD_MONO_IO0 = 16'h03B4;
  localparam logic [15:0] HAMD_MONO_IO1 = 16'h03B5;
  localparam logic [15:0] HAMD_MONO_IO2 = 16'h03B8;
  localparam logic [15:0] HAMD_MONO_IO3 = 16'h03B9;
  localparam logic [15:0] HAMD_MONO_IO4 = 16'h03BA;
  localparam logic [15:0] HAMD_MONO_IO5 = 16'h03BF;

  // One-hot decode targets
  typedef enum logic [4:0] {
    HAMD_TGT_MEM = 5'h01,
    HAMD_TGT_IGU = 5'h02,
    HAMD_TGT_GPORT = 5'h04,
    HAMD_TGT_HUB = 5'h08,
    HAMD_TGT_ABORT = 5'h10
  } hamd_tgt_t;

  // Cycle originator
  typedef enum logic [1:0] {
    HAMD_SRC_PROC = 2'h0,
    HAMD_SRC_GPORT = 2'h1,
    HAMD_SRC_HUB = 2'h2
  } hamd_src_t;

endpackage : hamd_pkg

// File: hamd_decoder.sv
// Host cycle address decoder with Avalon-MM configuration registers
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module hamd_decoder
  import hamd_pkg::*;
#(
  parameter logic [31:0] HIGH_SEG_BASE = 32'hFEDA_0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic host_valid,
  input wire logic [31:0] host_addr,
  input wire logic host_io,
  input wire logic host_write,
  input wire logic host_writeback,
  input wire logic host_smm,
  input wire logic [1:0] host_source,
  output logic dec_valid,
  output logic [4:0] dec_target,
  output logic [31:0] dec_addr
);

  logic [25:0] seg_attr_reg, seg_attr_next;
  logic [9:0] legacy_ctrl_reg, legacy_ctrl_next;
  logic [11:0] top_main_reg, top_main_next;
  logic [1:0] mgmt_size_reg, mgmt_size_next;
  logic [4:0] status_reg, status_next;
  logic [31:0] avs_readdata_reg, avs_readdata_next;
  logic avs_waitrequest_reg, avs_waitrequest_next;
  logic dec_valid_reg, dec_valid_next;
  logic [4:0] dec_target_reg, dec_target_next;
  logic [31:0] dec_addr_reg, dec_addr_next;

  logic [HAMD_NUM_SEGS-1:0] seg_re, seg_we;
  logic [31:0] reg_value, reg_merged;
  logic [31:0] top_main, gfx_size, top_size, gfx_base, top_sys;
  logic vga_en, mono_present, igu_en, compat_en, high_en, top_en, hole_en;
  logic is_proc, in_low, in_vga, in_mono, in_seg, in_high, in_hole, in_gfx, in_top, above_top;
  logic mono_port, seg_enable;
  logic [3:0] seg_idx;
  hamd_tgt_t vga_tgt, mono_tgt, tgt;

  // Per-segment attribute split
  genvar g;
  generate
    for (g = 0; g < HAMD_NUM_SEGS; g++) begin : g_seg
      assign seg_re[g] = seg_attr_reg[2*g];
      assign seg_we[g] = seg_attr_reg[2*g+1];
    end
  endgenerate

  assign vga_en = legacy_ctrl_reg[HAMD_LC_VGA_EN];
  assign mono_present = legacy_ctrl_reg[HAMD_LC_MONO_PRESENT];
  assign igu_en = legacy_ctrl_reg[HAMD_LC_IGU_EN];
  assign compat_en = legacy_ctrl_reg[HAMD_LC_COMPAT_EN];
  assign high_en = legacy_ctrl_reg[HAMD_LC_HIGH_EN];
  assign top_en = legacy_ctrl_reg[HAMD_LC_TOP_EN];
  assign hole_en = legacy_ctrl_reg[HAMD_LC_HOLE_EN];

  // Memory layout: usable memory, then top segment, then graphics block
  always_comb begin
    top_main = {top_main_reg, HAMD_MB_LOW_ZERO};
    gfx_size = '0;
    if (igu_en) begin
      case (legacy_ctrl_reg[HAMD_LC_GFX_HI:HAMD_LC_GFX_LO])
        2'h0: gfx_size = HAMD_GFX_512K;
        2'h1: gfx_size = HAMD_GFX_1M;
        default: gfx_size = HAMD_GFX_8M;
      endcase
    end
    // Size field picks 128 KB, 256 KB, 512 KB or 1 MB, so never more than 1 MB
    top_size = top_en ? (HAMD_TOP_MIN_SIZE << mgmt_size_reg) : '0;
    gfx_base = top_main - gfx_size;
    top_sys = gfx_base - top_size;
  end

  // Address range flags
  assign is_proc = (host_source == HAMD_SRC_PROC);
  assign in_low = (host_addr <= HAMD_LOW_DRAM_END);
  assign in_vga = (host_addr >= HAMD_VGA_BASE) && (host_addr <= HAMD_VGA_END);
  assign in_mono = (host_addr >= HAMD_MONO_BASE) && (host_addr <= HAMD_MONO_END);
  assign in_seg = (host_addr >= HAMD_SEG_BASE) && (host_addr <= HAMD_SEG_END);
  assign in_high = high_en && (host_addr >= HIGH_SEG_BASE) && (host_addr - HIGH_SEG_BASE < HAMD_HIGH_SIZE);
  assign above_top = (host_addr >= top_main);
  assign in_hole = hole_en && (host_addr >= HAMD_HOLE_BASE) && (host_addr <= HAMD_HOLE_END);
  assign in_gfx = (host_addr >= gfx_base) && !above_top;
  assign in_top = top_en && (host_addr >= top_sys) && (host_addr < gfx_base);
  assign mono_port = (host_addr[15:0] == HAMD_MONO_IO0) || (host_addr[15:0] == HAMD_MONO_IO1) ||
                     (host_addr[15:0] == HAMD_MONO_IO2) || (host_addr[15:0] == HAMD_MONO_IO3) ||
                     (host_addr[15:0] == HAMD_MONO_IO4) || (host_addr[15:0] == HAMD_MONO_IO5);
  // C0000h-DFFFFh and E0000h-EFFFFh map to 16 KB slots 0..11, F0000h-FFFFFh is slot 12
  assign seg_idx = (host_addr[19:16] == HAMD_BIOS_NIBBLE) ? 4'(HAMD_BIOS_SEG) : host_addr[17:14];
  assign seg_enable = host_write ? seg_we[seg_idx] : seg_re[seg_idx];

  // Cycle decode
  always_comb begin
    vga_tgt = igu_en ? HAMD_TGT_IGU : (vga_en ? HAMD_TGT_GPORT : HAMD_TGT_HUB);
    mono_tgt = mono_present ? HAMD_TGT_HUB : vga_tgt;
    tgt = HAMD_TGT_HUB;
    dec_addr_next = host_addr;
    if (host_io) begin
      tgt = mono_port ? mono_tgt : HAMD_TGT_HUB;
    end else if (in_low) begin
      tgt = HAMD_TGT_MEM;
    end else if (in_vga) begin
      if (compat_en && is_proc && host_smm) begin
        tgt = HAMD_TGT_MEM;
      end else if (in_mono) begin
        tgt = mono_tgt;
      end else begin
        tgt = vga_tgt;
      end
    end else if (in_seg) begin
      // Disabled segments are not remapped anywhere
      tgt = seg_enable ? HAMD_TGT_MEM : HAMD_TGT_HUB;
    end else if (in_high) begin
      if (is_proc && (host_smm || host_writeback)) begin
        // Only the remapped address is driven; DRAM at the high address is never reached
        tgt = HAMD_TGT_MEM;
        dec_addr_next = HAMD_VGA_BASE + (host_addr - HIGH_SEG_BASE);
      end else if (is_proc) begin
        tgt = HAMD_TGT_ABORT;
      end else begin
        tgt = HAMD_TGT_HUB;
      end
    end else if (above_top) begin
      tgt = HAMD_TGT_HUB;
    end else if (in_hole) begin
      tgt = HAMD_TGT_HUB;
    end else if (in_gfx) begin
      tgt = HAMD_TGT_IGU;
    end else if (in_top) begin
      if (is_proc && (host_smm || host_writeback)) begin
        tgt = HAMD_TGT_MEM;
      end else if (is_proc) begin
        tgt = HAMD_TGT_ABORT;
      end else begin
        tgt = HAMD_TGT_HUB;
      end
    end else begin
      tgt = HAMD_TGT_MEM;
    end
    dec_valid_next = host_valid;
    dec_target_next = host_valid ? tgt : dec_target_reg;
    status_next = host_valid ? tgt : status_reg;
    if (!host_valid) begin
      dec_addr_next = dec_addr_reg;
    end
  end

  // Register read mux, shared by reads and byte-lane merging of writes
  always_comb begin
    case (avs_address)
      HAMD_OFS_SEG_ATTR: reg_value = {6'h00, seg_attr_reg};
      HAMD_OFS_LEGACY_CTRL: reg_value = {22'h000000, legacy_ctrl_reg};
      HAMD_OFS_TOP_MAIN: reg_value = top_main;
      HAMD_OFS_MGMT_SIZE: reg_value = {30'h00000000, mgmt_size_reg};
      HAMD_OFS_STATUS: reg_value = {27'h0000000, status_reg};
      HAMD_OFS_TOP_SYS: reg_value = top_sys;
      default: reg_value = '0;
    endcase
    for (int i = 0; i < 4; i++) begin
      reg_merged[8*i +: 8] = avs_byteenable[i] ? avs_writedata[8*i +: 8] : reg_value[8*i +: 8];
    end
  end

  // Bus slave: one wait cycle per access; writes land on the accepting edge
  always_comb begin
    avs_waitrequest_next = !((avs_read || avs_write) && avs_waitrequest_reg);
    avs_readdata_next = (avs_read && avs_waitrequest_reg) ? reg_value : avs_readdata_reg;
    seg_attr_next = seg_attr_reg;
    legacy_ctrl_next = legacy_ctrl_reg;
    top_main_next = top_main_reg;
    mgmt_size_next = mgmt_size_reg;
    if (avs_write && !avs_waitrequest_reg) begin
      case (avs_address)
        HAMD_OFS_SEG_ATTR: seg_attr_next = reg_merged[25:0];
        HAMD_OFS_LEGACY_CTRL: legacy_ctrl_next = reg_merged[9:0];
        HAMD_OFS_TOP_MAIN: top_main_next = reg_merged[31:20];
        HAMD_OFS_MGMT_SIZE: mgmt_size_next = reg_merged[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_attr_reg <= HAMD_SEG_ATTR_RST;
      legacy_ctrl_reg <= HAMD_LEGACY_CTRL_RST;
      top_main_reg <= HAMD_TOP_MAIN_RST;
      mgmt_size_reg <= HAMD_MGMT_SIZE_RST;
      status_reg <= '0;
      avs_readdata_reg <= '0;
      avs_waitrequest_reg <= 1'b1;
      dec_valid_reg <= 1'b0;
      dec_target_reg <= '0;
      dec_addr_reg <= '0;
    end else begin
      seg_attr_reg <= seg_attr_next;
      legacy_ctrl_reg <= legacy_ctrl_next;
      top_main_reg <= top_main_next;
      mgmt_size_reg <= mgmt_size_next;
      status_reg <= status_next;
      avs_readdata_reg <= avs_readdata_next;
      avs_waitrequest_reg <= avs_waitrequest_next;
      dec_valid_reg <= dec_valid_next;
      dec_target_reg <= dec_target_next;
      dec_addr_reg <= dec_addr_next;
    end
  end

  assign avs_readdata = avs_readdata_reg;
  assign avs_waitrequest = avs_waitrequest_reg;
  assign dec_valid = dec_valid_reg;
  assign dec_target = dec_target_reg;
  assign dec_addr = dec_addr_reg;

  low_dram_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_low |=> dec_valid && dec_target == HAMD_TGT_MEM && dec_addr == $past(host_addr))
    else $error("low region not sent to memory");

  vga_igu_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_vga && igu_en && !in_mono && !(compat_en && is_proc && host_smm)
    |=> dec_target == HAMD_TGT_IGU)
    else $error("video range missed internal graphics");

  compat_smm_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_vga && compat_en && is_proc && host_smm
    |=> dec_target == HAMD_TGT_MEM && dec_addr == $past(host_addr))
    else $error("management video access not sent to DRAM");

  compat_other_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_vga && !is_proc |=> dec_target != HAMD_TGT_MEM)
    else $error("foreign cycle reached management RAM");

  mono_io_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && host_io && mono_port && mono_present |=> dec_target == HAMD_TGT_HUB)
    else $error("mono port not sent to hub link");

  seg_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_seg && !seg_enable |=> dec_target == HAMD_TGT_HUB)
    else $error("disabled segment not sent to hub link");

  bios_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> seg_re[HAMD_BIOS_SEG] == 1'b0 && seg_we[HAMD_BIOS_SEG] == 1'b0)
    else $error("bios segment not disabled after reset");

  hole_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_hole && !above_top && !in_high |=> dec_target == HAMD_TGT_HUB)
    else $error("fixed hole not sent to hub link");

  high_remap_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_high && is_proc && host_smm
    |=> dec_target == HAMD_TGT_MEM && dec_addr == $past(host_addr) - HIGH_SEG_BASE + HAMD_VGA_BASE)
    else $error("high segment not remapped");

  high_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_high && is_proc && !host_smm && !host_writeback
    |=> dec_target == HAMD_TGT_ABORT)
    else $error("high segment access not aborted");

  top_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && !in_low && !in_vga && !in_seg && !in_high && !above_top && !in_hole &&
    !in_gfx && in_top && is_proc && !host_smm && !host_writeback |=> dec_target == HAMD_TGT_ABORT)
    else $error("top segment access not aborted");

  one_target_a: assert property (@(posedge clk) disable iff (!rst_n)
    dec_valid |-> $onehot(dec_target))
    else $error("decode result not one-hot");

  valid_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid |=> dec_valid)
    else $error("decode answer missing one cycle after request");

  valid_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !host_valid |=> !dec_valid && $stable(dec_target) && $stable(dec_addr))
    else $error("decode result changed without a request");

  vga_steer_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_vga && !in_mono && !igu_en && !(compat_en && is_proc && host_smm)
    |=> dec_target == (vga_en ? HAMD_TGT_GPORT : HAMD_TGT_HUB))
    else $error("video range not steered by enable bit");

  mono_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_mono && mono_present && !(compat_en && is_proc && host_smm)
    |=> dec_target == HAMD_TGT_HUB)
    else $error("mono range not sent to hub link");

  seg_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_seg && seg_enable |=> dec_target == HAMD_TGT_MEM)
    else $error("enabled segment not sent to memory");

  main_mem_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && host_addr > HAMD_SEG_END && !in_high && !above_top && !in_hole &&
    !in_gfx && !in_top |=> dec_target == HAMD_TGT_MEM)
    else $error("main memory range not sent to memory");

  above_top_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && host_addr > HAMD_SEG_END && !in_high && above_top
    |=> dec_target == HAMD_TGT_HUB)
    else $error("range above top of memory not sent to hub link");

  top_smm_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && host_addr > HAMD_SEG_END && !in_high && !above_top && !in_hole &&
    !in_gfx && in_top && is_proc && host_smm
    |=> dec_target == HAMD_TGT_MEM && dec_addr == $past(host_addr))
    else $error("management top segment access not sent to DRAM");

  high_foreign_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && in_high && !is_proc |=> dec_target == HAMD_TGT_HUB)
    else $error("foreign high segment cycle not sent to hub link");

  gfx_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    host_valid && !host_io && host_addr > HAMD_SEG_END && !in_high && !above_top && !in_hole && in_gfx
    |=> dec_target == HAMD_TGT_IGU)
    else $error("graphics block not sent to internal graphics");

endmodule : hamd_decoder

`default_nettype wire

// File: hamd_host_model.sv
// Host bus side model that issues one decode cycle and collects the answer
`timescale 1ns/10ps
`default_nettype none
module hamd_host_model
  import hamd_pkg::*;
(
  input wire logic clk,
  output logic host_valid,
  output logic [31:0] host_addr,
  output logic host_io,
  output logic host_write,
  output logic host_writeback,
  output logic host_smm,
  output logic [1:0] host_source,
  input wire logic dec_valid,
  input wire logic [4:0] dec_target,
  input wire logic [31:0] dec_addr
);
  initial begin
    host_valid = 1'b0;
    host_addr = 32'h0;
    {host_io, host_write, host_writeback, host_smm, host_source} = 6'h00;
  end

  // Qualifiers are inverted outside a cycle so a stale value never passes for a fresh one
  task automatic cyc(input logic [31:0] a, input logic [5:0] k, output logic [4:0] tg, output logic [31:0] ad,
                     output int lat);
    int n;
    n = 0;
    host_addr <= a;
    {host_io, host_write, host_writeback, host_smm, host_source} <= k;
    host_valid <= 1'b1;
    @(posedge clk);
    host_valid <= 1'b0;
    host_addr <= ~a;
    {host_io, host_write, host_writeback, host_smm, host_source} <= ~k;
    do begin
      @(posedge clk);
      n++;
    end while (dec_valid !== 1'b1);
    tg = dec_target;
    ad = dec_addr;
    lat = n;
  endtask : cyc
endmodule : hamd_host_model
`default_nettype wire

// File: hamd_decoder_tb.sv
// Self-checking testbench for the host address map decoder
`timescale 1ns/10ps
`default_nettype none
module hamd_decoder_tb
  import hamd_pkg::*;
;
  localparam logic [5:0] K_PR = 6'h00, K_IO = 6'h20, K_WR = 6'h10, K_WB = 6'h08, K_SM = 6'h04;
  localparam logic [5:0] K_HB = 6'h02, K_GP = 6'h01;
  localparam logic [4:0] T_M = HAMD_TGT_MEM, T_I = HAMD_TGT_IGU, T_G = HAMD_TGT_GPORT;
  localparam logic [4:0] T_H = HAMD_TGT_HUB, T_A = HAMD_TGT_ABORT;
  logic clk = 1'b0;
  logic rst_n, avs_read, avs_write, avs_waitrequest, host_valid, host_io, host_write;
  logic host_writeback, host_smm, dec_valid;
  logic [4:0] avs_address, dec_target;
  logic [31:0] avs_writedata, avs_readdata, host_addr, dec_addr, ts;
  logic [3:0] avs_byteenable;
  logic [1:0] host_source;
  int n_errors = 0;
  int compares = 0;
  logic [9:0] vc [5] = '{10'h0, 10'h1, 10'h3, 10'h5, 10'h7};
  logic [4:0] ve [5] = '{T_H, T_G, T_G, T_I, T_I};
  logic [4:0] me [5] = '{T_H, T_G, T_H, T_I, T_H};
  logic [15:0] mp [6] = '{HAMD_MONO_IO0, HAMD_MONO_IO1, HAMD_MONO_IO2, HAMD_MONO_IO3, HAMD_MONO_IO4, HAMD_MONO_IO5};
  logic [31:0] gs [3] = '{HAMD_GFX_512K, HAMD_GFX_1M, HAMD_GFX_8M};

  hamd_decoder hamd_decoder_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .host_valid(host_valid),
    .host_addr(host_addr), .host_io(host_io), .host_write(host_write), .host_writeback(host_writeback),
    .host_smm(host_smm), .host_source(host_source), .dec_valid(dec_valid), .dec_target(dec_target),
    .dec_addr(dec_addr));
  hamd_host_model hamd_host_model_i (.clk(clk), .host_valid(host_valid), .host_addr(host_addr),
    .host_io(host_io), .host_write(host_write), .host_writeback(host_writeback), .host_smm(host_smm),
    .host_source(host_source), .dec_valid(dec_valid), .dec_target(dec_target), .dec_addr(dec_addr));

  always #5 clk = ~clk;

  task automatic final_report;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request is held until waitrequest is sampled low, then released right after that edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : acc

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] q;
    acc(1'b1, a, d, be, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask : rd

  task automatic hc(input logic [31:0] a, input logic [5:0] k, input logic [4:0] e, input logic [31:0] ea = '1);
    logic [4:0] tg;
    logic [31:0] ad;
    int lat;
    hamd_host_model_i.cyc(a, k, tg, ad, lat);
    chk(32'(lat), 32'h1);
    chk(32'(tg), 32'(e));
    if (ea !== '1) chk(ad, ea);
  endtask : hc

  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(dec_target), 32'h0);
    chk(32'(avs_waitrequest), 32'h1);
    rd(HAMD_OFS_SEG_ATTR, 32'h0);
    rd(HAMD_OFS_LEGACY_CTRL, 32'h0);
    hc(32'h0, K_PR, T_M, 32'h0);
    hc(32'h0009_FFFF, K_SM | K_HB, T_M);
    hc(32'h000F_0000, K_PR, T_H);
    hc(32'h000F_FFFF, K_WR, T_H);
    hc(32'h000C_0000, K_PR, T_H);
    hc(32'h000E_0000, K_WR, T_H);
    wr(HAMD_OFS_SEG_ATTR, 32'h03FF_FFFF, 4'h1);
    rd(HAMD_OFS_SEG_ATTR, 32'h0000_00FF);
    // Even segments read-only, odd segments write-only
    wr(HAMD_OFS_SEG_ATTR, 32'h0199_9999);
    for (int k = 0; k < 13; k++) begin
      ts = (k < 12) ? 32'h000C_0000 + 32'(k) * 32'h4000 + 32'h3FFF : 32'h000F_0000;
      hc(ts, K_PR, (k % 2) ? T_H : T_M);
      hc(ts, K_WR, (k % 2) ? T_M : T_H);
    end
    for (int c = 0; c < 5; c++) begin
      wr(HAMD_OFS_LEGACY_CTRL, 32'(vc[c]));
      hc(32'h000A_8000, K_PR, ve[c]);
      hc(32'h000B_0000, K_WR, me[c]);
      hc(32'h000B_7FFF, K_PR, me[c]);
      for (int p = 0; p < 6; p++) hc({16'h0, mp[p]}, K_IO, me[c]);
      hc(32'h0000_03C0, K_IO, T_H);
    end
    wr(HAMD_OFS_LEGACY_CTRL, 32'h9);
    hc(32'h000A_0000, K_SM, T_M, 32'h000A_0000);
    hc(32'h000B_FFFF, K_PR, T_G);
    hc(32'h000A_0000, K_SM | K_GP, T_G);
    hc(32'h000A_0000, K_SM | K_HB, T_G);
    wr(HAMD_OFS_TOP_MAIN, 32'h0400_0000);
    rd(HAMD_OFS_TOP_MAIN, 32'h0400_0000);
    wr(HAMD_OFS_LEGACY_CTRL, 32'h40);
    hc(32'h0010_0000, K_PR, T_M);
    hc(32'h00EF_FFFF, K_PR, T_M);
    hc(32'h00F0_0000, K_PR, T_H);
    hc(32'h00FF_FFFF, K_WR, T_H);
    hc(32'h0100_0000, K_PR, T_M);
    hc(32'h0400_0000, K_PR, T_H);
    hc(32'hFFFF_FFFF, K_WR, T_H);
    wr(HAMD_OFS_LEGACY_CTRL, 32'h10);
    hc(32'h00F0_0000, K_PR, T_M);
    hc(32'hFEDA_1234, K_SM, T_M, 32'h000A_1234);
    hc(32'hFEDB_FFFF, K_SM | K_WR, T_M, 32'h000B_FFFF);
    hc(32'hFEDA_0000, K_PR, T_A);
    hc(32'hFEDA_0010, K_WR | K_WB, T_M, 32'h000A_0010);
    hc(32'hFEDA_0000, K_SM | K_GP, T_H);
    hc(32'hFEDC_0000, K_SM, T_H);
    rd(HAMD_OFS_STATUS, 32'(T_H));
    wr(HAMD_OFS_STATUS, 32'h0);
    rd(HAMD_OFS_STATUS, 32'(T_H));
    wr(5'h18, 32'hFFFF_FFFF);
    rd(5'h18, 32'h0);
    wr(HAMD_OFS_TOP_SYS, 32'h0);
    for (int g = 0; g < 3; g++) begin
      wr(HAMD_OFS_LEGACY_CTRL, 32'h24 | (32'(g) << 8));
      ts = 32'h0400_0000 - gs[g] - HAMD_TOP_MIN_SIZE;
      rd(HAMD_OFS_TOP_SYS, ts);
      hc(32'h0400_0000 - gs[g], K_PR, T_I);
      hc(ts, K_PR, T_A);
      hc(ts - 32'h1, K_PR, T_M);
    end
    wr(HAMD_OFS_LEGACY_CTRL, 32'h124);
    for (int n = 0; n < 4; n++) begin
      wr(HAMD_OFS_MGMT_SIZE, 32'(n));
      ts = 32'h03F0_0000 - (32'h0002_0000 << n);
      rd(HAMD_OFS_TOP_SYS, ts);
      hc(ts, K_SM, T_M, ts);
      hc(ts + 32'h1_FFFF, K_PR, T_A);
      hc(ts, K_WR | K_WB, T_M, ts);
      hc(ts, K_SM | K_HB, T_H);
    end
    final_report();
  end
endmodule : hamd_decoder_tb
`default_nettype wire
